// file: pkg/serial_clock_defs.vh
/*
  Constants for the serial unit clock and channel 0 mode block: register
  offsets, field positions, reset values and divider widths.
  Assumes it is included by bare name from the design files under verilog/.
*/
//
// Behaviour
// R1: Peripheral enable bit 2 gates the serial unit's input clock on or off.
// R2: Prescaler holds two 4-bit fields, each dividing system clock by 2^field.
// R3: Bits 3:0 set first prescaled clock, bits 7:4 second; bits 15:8 read zero.
// R4: Mode bit 15 picks first (0) or second (1) prescaled clock as operation clock.
// R5: Mode bit 14: 0 divides operation clock, 1 takes external serial clock pin.
// R6: Mode bits 2:1 select clocked serial, UART, simplified I2C; 11 prohibited.
// R7: Mode bit 0 picks transfer-end (0) or buffer-empty (1) as interrupt source.
// R8: Divider bits 15:9 value N give transfer clock = operation clock / 2(N+1).
// R9: Software enables the unit clock before writing prescaler and mode.
`ifndef SERIAL_CLOCK_DEFS_VH
`define SERIAL_CLOCK_DEFS_VH

// Register word indices, compared with haddr[4:2]
`define OFS_PERIPH_ENABLE   3'h0
`define OFS_PRESCALER       3'h1
`define OFS_CHANNEL_MODE    3'h2
`define OFS_DATA_DIVIDER    3'h3
`define OFS_IRQ_STATUS      3'h4
`define OFS_IRQ_MASK        3'h5
`define OFS_CHANNEL_STATUS  3'h6

// Peripheral enable register
`define PER_UNIT_EN_BIT     2
`define PER_WRITABLE_MASK   8'hb5
`define PER_RESET           8'h00

// Prescaler register fields
`define PRS_FIELD0_LSB      0
`define PRS_FIELD1_LSB      4
`define PRS_RESET           8'h00
`define PRS_CNT_W           15

// Channel mode register fields
`define MODE_CKS_BIT        15
`define MODE_CCS_BIT        14
`define MODE_FIXED_ONE_BIT  5
`define MODE_MD_HI_BIT      2
`define MODE_MD_LO_BIT      1
`define MODE_INTSRC_BIT     0
`define MODE_RESET_MD       2'h1
`define MODE_PROHIBITED     2'h3

// Channel modes
`define MODE_CSI            2'h0
`define MODE_UART           2'h1
`define MODE_I2C            2'h2

// Data divider field
`define DIV_LSB             9
`define DIV_W               7
`define DIV_RESET           7'h00

// Interrupt status and mask bits
`define IRQ_CHANNEL_BIT     0
`define IRQ_BAD_MODE_BIT    1
`define IRQ_W               2

// AHB transfer types
`define HTRANS_NONSEQ       2'h2
`define HTRANS_SEQ          2'h3

`endif

// file: verilog/prescale_divider.v
/*
  Prescaler: one free counter on the system clock gives two strobes, each
  one cycle wide, at system clock divided by two to the power of its field.
  Assumes run is the gated unit clock enable and ce the global freeze.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_clock_defs.vh"

module prescale_divider (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       ce,
  // Control
  input  wire       run,
  input  wire [7:0] prs_fields,
  // Divided clock strobes
  output wire [1:0] prs_tick
);

  reg [`PRS_CNT_W-1:0] cnt_q;
  reg [1:0]            tick_q;

  // Low bits of the counter that must all be set for a divide by 2^k
  function [`PRS_CNT_W-1:0] low_mask;
    input [3:0] k;
    begin
      low_mask = ~({`PRS_CNT_W{1'b1}} << k);
    end
  endfunction

  // Counter clears to zero while the unit clock is off so strobes restart phase-aligned
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {`PRS_CNT_W{1'b0}};
    end else if (ce) begin
      if (run) begin
        cnt_q <= cnt_q + 1'b1; // R1
      end else begin
        cnt_q <= {`PRS_CNT_W{1'b0}};
      end
    end
  end

  // One strobe per prescaler field; field 0 gives a strobe every cycle
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_tick
      wire [`PRS_CNT_W-1:0] m = low_mask(prs_fields[4*g+3:4*g]);
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          tick_q[g] <= 1'b0;
        end else if (ce) begin
          tick_q[g] <= run & ((cnt_q & m) == m); // R2 R3
        end
      end
    end
  endgenerate

  assign prs_tick = tick_q;

endmodule
`default_nettype wire

// file: verilog/transfer_clock_gen.v
/*
  Channel transfer clock: either the operation clock divided by 2(N+1), or
  the external serial clock pin. Gives the level and a rising-edge strobe.
  Assumes sck_in is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_clock_defs.vh"

module transfer_clock_gen (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              ce,
  // Control
  input  wire              run,
  input  wire              op_tick,
  input  wire              ext_sel,
  input  wire [`DIV_W-1:0] div_n,
  input  wire              sck_in,
  // Transfer clock
  output wire              channel_transfer_clock_level,
  output wire              channel_transfer_clock_rise
);

  reg [`DIV_W-1:0] cnt_q;
  reg              lvl_q;
  reg              rise_q;
  reg              sck_prev_q;

  // Half period is N+1 operation ticks, full period 2(N+1)
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q      <= {`DIV_W{1'b0}};
      lvl_q      <= 1'b0;
      rise_q     <= 1'b0;
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_in;
      rise_q     <= 1'b0;
      if (!run) begin
        cnt_q <= {`DIV_W{1'b0}};
        lvl_q <= 1'b0;
      end else if (ext_sel) begin
        cnt_q  <= {`DIV_W{1'b0}};
        lvl_q  <= sck_in; // R5
        rise_q <= sck_in & ~sck_prev_q;
      end else if (op_tick) begin
        if (cnt_q == div_n) begin
          cnt_q  <= {`DIV_W{1'b0}};
          lvl_q  <= ~lvl_q; // R8
          rise_q <= ~lvl_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign channel_transfer_clock_level = lvl_q;
  assign channel_transfer_clock_rise  = rise_q;

endmodule
`default_nettype wire

// file: verilog/serial_clock_setup.v
/*
  Serial unit clock and channel 0 mode setup: AHB-Lite register file, unit
  clock gate, prescaler, operation clock select, transfer clock source and
  channel mode, plus a sticky interrupt status with mask.
  Assumes a single AHB-Lite master, word transfers, and channel event
  pulses from the channel datapath synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_clock_defs.vh"

module serial_clock_setup (
  // Clock, reset, freeze
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Serial clock pin and channel events
  input  wire        sck_in,
  input  wire        transfer_end_evt,
  input  wire        buffer_empty_evt,
  // Clocking towards the channel
  output wire        serial_unit_clock_enable,
  output wire        first_prescaled_clock,
  output wire        second_prescaled_clock,
  output wire        operation_clock_tick,
  output wire        channel_transfer_clock,
  output wire        transfer_clock_tick,
  // Channel mode towards the channel
  output wire [1:0]  channel_mode,
  output wire        channel_event,
  // Interrupt
  output wire        irq
);

  // Registers
  reg  [7:0]        per_q;
  reg  [7:0]        prs_q;
  reg               cks_q;
  reg               ccs_q;
  reg  [1:0]        md_q;
  reg               intsrc_q;
  reg  [`DIV_W-1:0] div_q;
  reg  [`IRQ_W-1:0] status_q;
  reg  [`IRQ_W-1:0] status_d;
  reg  [`IRQ_W-1:0] mask_q;
  reg               chan_evt_q;
  reg  [31:0]       hrdata_q;
  reg  [31:0]       rd_d;

  // Data phase bookkeeping
  reg               wr_pend_q;
  reg  [2:0]        wr_idx_q;

  wire              unit_en;
  wire [1:0]        prs_tick;
  wire              op_tick;
  wire              channel_transfer_clock_level;
  wire              channel_transfer_clock_rise;
  wire              addr_phase;
  wire              wr_now;
  wire              cfg_wr_ok;
  wire [15:0]       mode_word;
  wire [1:0]        new_md;
  wire              chan_evt_src;
  wire [`IRQ_W-1:0] status_set;
  wire [`IRQ_W-1:0] status_clr;

  // Per-register write strikes, all taken in the data phase
  wire              hit_per;
  wire              hit_prs;
  wire              hit_mode;
  wire              hit_div;
  wire              hit_stat;
  wire              hit_mask;

  // Write decode shared by every register; the index was captured in the
  // address phase, so a later address on the bus cannot redirect the write
  function wr_hit;
    input       pend;
    input [2:0] idx;
    input [2:0] want;
    begin
      wr_hit = pend & (idx == want);
    end
  endfunction

  // Unit clock gate
  assign unit_en = per_q[`PER_UNIT_EN_BIT]; // R1

  // Operation clock picks one of the two prescaled strobes
  assign op_tick = cks_q ? prs_tick[1] : prs_tick[0]; // R4

  prescale_divider u_prescale (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .run        (unit_en),
    .prs_fields (prs_q),
    .prs_tick   (prs_tick)
  );

  transfer_clock_gen u_channel_transfer_clock (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .run        (unit_en),
    .op_tick    (op_tick),
    .ext_sel    (ccs_q),
    .div_n      (div_q),
    .sck_in     (sck_in),
    .channel_transfer_clock_level (channel_transfer_clock_level),
    .channel_transfer_clock_rise  (channel_transfer_clock_rise)
  );

  // Bus handshake: zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;
  assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign wr_now     = wr_pend_q & hready;

  // A stopped unit clock cannot take configuration; such writes are dropped
  assign cfg_wr_ok  = unit_en; // R9

  // One strike per register; configuration strikes also need the unit clock.
  // The enable and interrupt registers stay writable so software can always
  // wake the unit and service its interrupt.
  assign hit_per  = wr_hit(wr_now, wr_idx_q, `OFS_PERIPH_ENABLE);
  assign hit_prs  = wr_hit(wr_now & cfg_wr_ok, wr_idx_q, `OFS_PRESCALER);
  assign hit_mode = wr_hit(wr_now & cfg_wr_ok, wr_idx_q, `OFS_CHANNEL_MODE);
  assign hit_div  = wr_hit(wr_now & cfg_wr_ok, wr_idx_q, `OFS_DATA_DIVIDER);
  assign hit_stat = wr_hit(wr_now, wr_idx_q, `OFS_IRQ_STATUS);
  assign hit_mask = wr_hit(wr_now, wr_idx_q, `OFS_IRQ_MASK);

  // Write address and direction are held for the data phase
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 3'h0;
    end else if (ce) begin
      if (hready) begin
        wr_pend_q <= addr_phase & hwrite;
        wr_idx_q  <= haddr[4:2];
      end
    end
  end

  // Peripheral enable register; unimplemented bits stay zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_q <= `PER_RESET;
    end else if (ce) begin
      if (hit_per) begin
        per_q <= hwdata[7:0] & `PER_WRITABLE_MASK; // R1
      end
    end
  end

  // Prescaler fields, upper byte not stored so it reads zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prs_q <= `PRS_RESET;
    end else if (ce) begin
      if (hit_prs) begin
        prs_q <= hwdata[7:0]; // R2 R3
      end
    end
  end

  // Channel mode; a prohibited mode code keeps the old mode and flags it
  assign new_md = {hwdata[`MODE_MD_HI_BIT], hwdata[`MODE_MD_LO_BIT]};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cks_q    <= 1'b0;
      ccs_q    <= 1'b0;
      md_q     <= `MODE_RESET_MD;
      intsrc_q <= 1'b0;
    end else if (ce) begin
      if (hit_mode) begin
        cks_q    <= hwdata[`MODE_CKS_BIT]; // R4
        ccs_q    <= hwdata[`MODE_CCS_BIT]; // R5
        intsrc_q <= hwdata[`MODE_INTSRC_BIT]; // R7
        if (new_md != `MODE_PROHIBITED) begin
          md_q <= new_md; // R6
        end
      end
    end
  end

  // Transfer clock divider value
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= `DIV_RESET;
    end else if (ce) begin
      if (hit_div) begin
        div_q <= hwdata[`DIV_LSB+`DIV_W-1:`DIV_LSB]; // R8
      end
    end
  end

  // Channel interrupt source follows the selected event
  assign chan_evt_src = unit_en & (intsrc_q ? buffer_empty_evt : transfer_end_evt); // R7

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_evt_q <= 1'b0;
    end else if (ce) begin
      chan_evt_q <= chan_evt_src;
    end
  end

  // Sticky status: a new event wins over a write-one clear in the same cycle
  assign status_set[`IRQ_CHANNEL_BIT]  = chan_evt_src;
  assign status_set[`IRQ_BAD_MODE_BIT] = hit_mode & (new_md == `MODE_PROHIBITED); // R6
  // Clear only the bits written as one; zeros leave pending events alone
  assign status_clr = hit_stat ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  always @* begin
    status_d = (status_q & ~status_clr) | status_set;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= {`IRQ_W{1'b0}};
      mask_q   <= {`IRQ_W{1'b0}};
    end else if (ce) begin
      status_q <= status_d;
      if (hit_mask) begin
        mask_q <= hwdata[`IRQ_W-1:0];
      end
    end
  end

  // Mode register image, bit 5 reads as a fixed one
  assign mode_word = {cks_q, ccs_q, 8'h00, 1'b1, 2'h0,
                      md_q[1], md_q[0], intsrc_q};

  // Read mux, sampled in the address phase and held through the data phase
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[4:2])
      `OFS_PERIPH_ENABLE:  rd_d = {24'h00_0000, per_q};
      `OFS_PRESCALER:      rd_d = {24'h00_0000, prs_q}; // R3
      `OFS_CHANNEL_MODE:   rd_d = {16'h0000, mode_word};
      `OFS_DATA_DIVIDER:   rd_d = {16'h0000, div_q, 9'h000};
      `OFS_IRQ_STATUS:     rd_d = {30'h0000_0000, status_q};
      `OFS_IRQ_MASK:       rd_d = {30'h0000_0000, mask_q};
      `OFS_CHANNEL_STATUS: rd_d = {28'h000_0000, unit_en, channel_transfer_clock_level, md_q};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses leave zero on the read bus; writes leave it unchanged
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (addr_phase && !hwrite) begin
        hrdata_q <= (haddr[31:5] == 27'h000_0000) ? rd_d : 32'h0000_0000;
      end
    end
  end

  // Outputs towards the channel
  assign serial_unit_clock_enable = unit_en;
  assign first_prescaled_clock    = prs_tick[0];
  assign second_prescaled_clock   = prs_tick[1];
  assign operation_clock_tick     = op_tick;
  assign channel_transfer_clock   = channel_transfer_clock_level;
  assign transfer_clock_tick      = channel_transfer_clock_rise;
  assign channel_mode             = md_q;
  assign channel_event            = chan_evt_q;
  assign irq                      = |(status_q & mask_q);

endmodule
`default_nettype wire

// file: bench/clk_setup_monitor.sv
/* Port checker for serial_clock_setup.
   Assumes it is bound to the top module and that ce is held high. */
`timescale 1ns/1ps
`default_nettype none
module clk_setup_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Channel side
  input wire logic        transfer_end_evt,
  input wire logic        buffer_empty_evt,
  input wire logic        serial_unit_clock_enable,
  input wire logic        first_prescaled_clock,
  input wire logic        second_prescaled_clock,
  input wire logic        operation_clock_tick,
  input wire logic        transfer_clock_tick,
  input wire logic [1:0]  channel_mode,
  input wire logic        channel_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Zero wait states, response always OKAY
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  // Read data only moves after a read address phase
  rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  // Unit clock only comes on from a bus write of bit 2
  unit_write_a: assert property ($rose(serial_unit_clock_enable) |->
    $past(hwdata[2]) && $past(hsel && hwrite && htrans[1], 2))
    else $error("unit clock enabled without a write");
  // Gated unit gives no strobes; two cycles of slack for the registered strobe
  gate_stop_a: assert property (!serial_unit_clock_enable && $past(!serial_unit_clock_enable)
    && $past(!serial_unit_clock_enable, 2) |-> !first_prescaled_clock && !second_prescaled_clock)
    else $error("prescaler strobe with unit clock off");
  op_source_a: assert property (operation_clock_tick |-> first_prescaled_clock || second_prescaled_clock)
    else $error("operation tick without a prescaler strobe");
  mode_legal_a: assert property (channel_mode != 2'h3)
    else $error("prohibited channel mode reached");
  evt_source_a: assert property (channel_event |-> $past(transfer_end_evt || buffer_empty_evt))
    else $error("channel event without a source event");
  tick_pulse_a: assert property (transfer_clock_tick |=> !transfer_clock_tick)
    else $error("transfer tick wider than one cycle");
endmodule
bind serial_clock_setup clk_setup_monitor mon (.sys_clk, .rst, .hsel, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .transfer_end_evt, .buffer_empty_evt,
  .serial_unit_clock_enable, .first_prescaled_clock, .second_prescaled_clock,
  .operation_clock_tick, .transfer_clock_tick, .channel_mode, .channel_event);
`default_nettype wire

// file: bench/uart_far_end.sv
/* Far side of channel 0: external serial clock and channel event pulses.
   Assumes its tasks are called just after a rising sys_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module uart_far_end (
  // Clock
  input  wire logic sys_clk,
  // Towards the block
  output var logic  sck,
  output var logic  end_evt,
  output var logic  empty_evt
);
  // Serial clock idles low: it only runs inside a frame
  initial begin
    sck = 1'b0;
    end_evt = 1'b0;
    empty_evt = 1'b0;
  end
  // One-cycle pulse; 0 transfer end, 1 buffer empty
  task pulse(input bit w);
    if (w) empty_evt <= 1'b1;
    else end_evt <= 1'b1;
    @(posedge sys_clk);
    end_evt <= 1'b0;
    empty_evt <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Slow frame so every edge survives the one-cycle sampling
  task frame(input int n);
    repeat (n) begin
      sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/test_serial_clock_setup.sv
/* Self-checking bench for serial_clock_setup.
   Assumes zero wait states are possible but waits on hreadyout anyway. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_clock_setup;
  logic        sys_clk, rst, ce, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire logic   hreadyout, hresp, sck_in, transfer_end_evt, buffer_empty_evt, irq;
  wire logic   serial_unit_clock_enable, first_prescaled_clock, second_prescaled_clock;
  wire logic   operation_clock_tick, channel_transfer_clock, transfer_clock_tick, channel_event;
  wire logic [1:0]  channel_mode;
  wire logic [31:0] hrdata;
  int          fail_count, checks_done;

  serial_clock_setup dut (.sys_clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sck_in, .transfer_end_evt,
    .buffer_empty_evt, .serial_unit_clock_enable, .first_prescaled_clock,
    .second_prescaled_clock, .operation_clock_tick, .channel_transfer_clock,
    .transfer_clock_tick, .channel_mode, .channel_event, .irq);
  uart_far_end far (.sys_clk, .sck(sck_in), .end_evt(transfer_end_evt),
    .empty_evt(buffer_empty_evt));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task summarize;
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Single word transfer; hsel stays up so it is never driven twice at one edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Extra edge so the written value is visible at the ports
  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(posedge sys_clk);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = first_prescaled_clock;
      1: pick = second_prescaled_clock;
      default: pick = transfer_clock_tick;
    endcase
  endfunction
  // Period in cycles; the first period is skipped as it may straddle a write
  task per(input int s, input int exp);
    int n;
    n = 0;
    repeat (2) do @(posedge sys_clk); while (pick(s) !== 1'b1);
    do begin
      @(posedge sys_clk);
      n++;
    end while (pick(s) !== 1'b1);
    chk(n, exp);
  endtask
  task ev(input bit w, input logic e);
    far.pulse(w);
    repeat (3) @(posedge sys_clk);
    chk(irq, e);
  endtask

  task t_reset;
    rdc(32'h0, 32'h0);
    rdc(32'h8, 32'h22);
    rdc(32'h1c, 32'h0);
    chk(channel_mode, 2'h1);
  endtask
  // Config writes are dropped until the unit clock runs
  task t_gate;
    wr(32'h4, 32'h11);
    rdc(32'h4, 32'h0);
    wr(32'h0, 32'hff);
    rdc(32'h0, 32'hb5);
    chk(serial_unit_clock_enable, 1'b1);
  endtask
  task t_prs;
    wr(32'h4, 32'hff21);
    rdc(32'h4, 32'h21);
    per(0, 2);
    per(1, 4);
    wr(32'h4, 32'h30);
    per(0, 1);
    per(1, 8);
  endtask
  task t_mode;
    for (int m = 0; m < 3; m++) begin
      wr(32'h8, m << 1);
      chk(channel_mode, m);
    end
    wr(32'h8, 32'h6);
    chk(channel_mode, 2'h2);
    rdc(32'h10, 32'h2);
    wr(32'h10, 32'h3);
    wr(32'h8, 32'h2);
  endtask
  // Divider at 1 and at its top value 127, second prescaler, then the external pin
  task t_channel_transfer_clock;
    int k;
    wr(32'h4, 32'h0);
    wr(32'hc, 32'h200);
    per(2, 4);
    wr(32'hc, 32'hfe00);
    per(2, 256);
    wr(32'hc, 32'h200);
    wr(32'h4, 32'h10);
    wr(32'h8, 32'h8002);
    per(2, 8);
    wr(32'h8, 32'h4002);
    k = 0;
    fork
      far.frame(4);
      repeat (40) begin
        @(posedge sys_clk);
        k += transfer_clock_tick;
      end
    join
    chk(k, 4);
  endtask
  // Source select, mask and write-one-to-clear
  task t_irq;
    wr(32'h14, 32'h1);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    wr(32'h10, 32'h1);
    chk(irq, 1'b0);
    wr(32'h8, 32'h3);
    ev(1'b1, 1'b1);
    wr(32'h14, 32'h0);
    chk(irq, 1'b0);
  endtask

  initial begin
    {rst, ce, hsel, hwrite, htrans, hsize} = {1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 3'h2};
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_gate;
    t_prs;
    t_mode;
    t_channel_transfer_clock;
    t_irq;
    summarize;
  end
  // Whole run is near one thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    summarize;
  end
endmodule
`default_nettype wire
